// *** rtl/ddc_map.svh ***
/*
  Register offsets, field positions and reset values of the display data channel slave.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef DDC_MAP_SVH
`define DDC_MAP_SVH

// Special function register offsets on the core's register port.
`define DDC_OFS_DDC_SETUP    8'hd1
`define DDC_OFS_BUS_SETUP    8'hd2
`define DDC_OFS_BUF_WINDOW   8'hd4
`define DDC_OFS_TX_BYTE      8'hd5
`define DDC_OFS_POINTER      8'hd6
`define DDC_OFS_CONTROL      8'hd7
`define DDC_OFS_SER_CONTROL  8'hd8
`define DDC_OFS_SER_STATUS   8'hd9
`define DDC_OFS_SER_DATA     8'hda
`define DDC_OFS_OWN_ADDR     8'hdb

// Reset values, and the byte sent while the prefetch buffer is empty.
`define DDC_RST_BYTE         8'h00
`define DDC_RST_OWN_ADDR     8'ha0
`define DDC_IDLE_BYTE        8'hff

// Hold-detect setup fields.
`define DDC_SETUP_EN         7
`define DDC_SETUP_CNT        6:0

// Control register fields.
`define DDC_CTL_SIZE         6
`define DDC_CTL_SWFEED       5
`define DDC_CTL_WILD         4
`define DDC_CTL_D1IRQ        3
`define DDC_CTL_D1EN         2
`define DDC_CTL_SWIRQ        1
`define DDC_CTL_MODE         0

// Serial control fields.
`define DDC_SCON_EN          6
`define DDC_SCON_ACK         2

// Serial status fields.
`define DDC_SSTA_STOP        6
`define DDC_SSTA_INTR        5
`define DDC_SSTA_TX          4
`define DDC_SSTA_NACK        1
`define DDC_SSTA_SLV         0

// Pointer masks for the two buffer sizes.
`define DDC_PTR_MASK_SMALL   8'h7f
`define DDC_PTR_MASK_LARGE   8'hff

// Bit counts of one transfer.
`define DDC_LAST_BIT         4'h7
`define DDC_BYTE_BITS        4'h8
`define DDC1_NULL_BIT        4'h8

`endif

// *** rtl/ddc_pkg.sv ***
/*
  Types of the display data channel slave: serial state enumeration and the state record.
  Assumes the constant header is on the include path.
*/
package ddc_pkg;
  `include "ddc_map.svh"

  typedef enum logic [2:0] {
    DDC_IDLE, DDC_ADDR, DDC_ACK, DDC_RX, DDC_TX, DDC_TX_ACK
  } ddc_phase_type;

  typedef struct packed {
    logic [1:0]    vs_sync;
    logic [1:0]    scl_sync;
    logic [1:0]    sda_sync;
    logic          div;
    logic          scl_f;
    logic          sda_f;
    logic [6:0]    scl_cnt;
    logic [6:0]    sda_cnt;
    logic          vs_prev;
    logic [7:0]    ddc_setup;
    logic [7:0]    bus_setup;
    logic [7:0]    tx_byte;
    logic [7:0]    ptr;
    logic [7:0]    ctrl;
    logic [7:0]    scon;
    logic [7:0]    ssta;
    logic [7:0]    sdat;
    logic [7:0]    sadr;
    ddc_phase_type phase;
    logic [3:0]    bits;
    logic [7:0]    shreg;
    logic          rw;
    logic          nack;
    logic [3:0]    d1_bits;
    logic [7:0]    d1_sh;
    logic          sda_oe;
    logic [7:0]    rdata;
    logic [7:0]    fifo0;
    logic [7:0]    fifo1;
    logic [1:0]    fifo_cnt;
  } ddc_state_type;
endpackage

// *** rtl/ddc_slave.sv ***
/*
  Display data channel slave: 256-byte display buffer, one-way vertical-sync mode and
  two-wire serial mode, start/stop hold filtering, and the core's register port.
  Assumes a synchronous core register port on the same clock and open-drain pads
  outside that turn sda_oe into a low level on the wire.
*/
// Notes on behaviour
// RQ1 - Own seven-bit address selects slave operation.
// RQ2 - Setup enable clear means one sample.
// RQ3 - Enabled setup needs field plus one samples.
// RQ4 - Sample clock is system clock halved.
// RQ5 - Two hold setup registers, both reset zero.
// RQ6 - 256-byte buffer filled by the core.
// RQ7 - Both modes run automatically from buffer.
// RQ8 - Slave only, never drives clock line.
// RQ9 - Sync, data, clock on one pin port.
// RQ10 - Transmit byte register, read/write, resets zero.
// RQ11 - Pointer increments after every window access.
// RQ12 - Post-increment in every mode and core access.
// RQ13 - Serial registers reused by this unit.
// RQ14 - Eight-bit shift register holds serial byte.
// RQ15 - Software feed interrupts per byte, else buffer.
// RQ16 - Sync mode off: ignore sync, serve serial.
// RQ17 - Mode switch sets sticky flag, stays serial.
// RQ18 - Wildcard ignores three low address bits.
// RQ19 - Window access uses pointer before increment.
// RQ20 - Core fills buffer before enabling the unit.
`timescale 1ns/1ps
`include "ddc_map.svh"

module ddc_slave
  import ddc_pkg::*;
#(
  parameter logic [7:0] OWN_ADDR_RESET = `DDC_RST_OWN_ADDR,
  parameter int         BUF_BYTES      = 256
) (
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       arst_n,
  // Core register port.
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // Port pins of the display link.
  input  wire logic       vsync_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Request levels to the core.
  output logic            ddc1_byte_irq,
  output logic            protocol_switch_irq,
  output logic            serial_irq
);

  ddc_state_type st;
  ddc_state_type next_st;
  logic [7:0]    buffer_mem [BUF_BYTES];

  // One hold filter step: the filtered level follows the pin only after it has been
  // stable for the programmed count plus one samples, which rejects glitches near edges.
  function automatic logic [7:0] hold_step(input logic raw, input logic filt,
                                           input logic [6:0] cnt, input logic smp,
                                           input logic [7:0] setup);
    logic [6:0] limit;
    limit = setup[`DDC_SETUP_EN] ? setup[`DDC_SETUP_CNT] : 7'h00; // RQ2 RQ3
    if (raw == filt) begin
      hold_step = {filt, 7'h00};
    end else if (!smp) begin
      hold_step = {filt, cnt};
    end else if (cnt == limit) begin
      hold_step = {raw, 7'h00};
    end else begin
      hold_step = {filt, cnt + 7'h01};
    end
  endfunction

  // Local decodes of the present state.
  logic       smp;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;
  logic       vs_rise;
  logic [7:0] ptr_mask;
  logic [7:0] mem_q;
  logic       serial_on;
  logic       ddc1_on;
  logic       win_wr;
  logic       win_rd;
  logic       fifo_pop;
  logic [7:0] fifo_q;
  logic [7:0] hs;
  logic [7:0] hc;
  logic       addr_hit;

  assign smp       = st.div; // RQ4
  assign ptr_mask  = st.ctrl[`DDC_CTL_SIZE] ? `DDC_PTR_MASK_LARGE : `DDC_PTR_MASK_SMALL;
  assign mem_q     = buffer_mem[st.ptr]; // RQ19
  assign win_wr    = sfr_wr && (sfr_addr == `DDC_OFS_BUF_WINDOW);
  assign win_rd    = sfr_rd && (sfr_addr == `DDC_OFS_BUF_WINDOW);
  assign ddc1_on   = st.ctrl[`DDC_CTL_D1EN] && !st.ctrl[`DDC_CTL_MODE];
  assign serial_on = st.scon[`DDC_SCON_EN] && !ddc1_on; // RQ16
  assign fifo_q    = (st.fifo_cnt != 2'h0) ? st.fifo0 : `DDC_IDLE_BYTE;

  // Wildcard compares only the upper four bits; otherwise the full seven-bit address.
  assign addr_hit  = st.ctrl[`DDC_CTL_WILD]
                   ? (st.shreg[7:4] == st.sadr[7:4])   // RQ18
                   : (st.shreg[7:1] == st.sadr[7:1]);  // RQ1

  // Edges of the filtered lines and of the synchronised sync pin.
  always_comb begin
    hs       = hold_step(st.sda_sync[1], st.sda_f, st.sda_cnt, smp, st.ddc_setup);
    hc       = hold_step(st.scl_sync[1], st.scl_f, st.scl_cnt, smp, st.ddc_setup);
    scl_rise = !st.scl_f && hc[7];
    scl_fall = st.scl_f && !hc[7];
    start_ev = st.scl_f && hc[7] && st.sda_f && !hs[7];
    stop_ev  = st.scl_f && hc[7] && !st.sda_f && hs[7];
    vs_rise  = st.vs_sync[1] && !st.vs_prev;
  end

  // All next-state logic. Later assignments override earlier ones, so core accesses
  // to the pointer win over the prefetch and the stall is local to that one cycle.
  always_comb begin
    next_st          = st;
    fifo_pop         = 1'b0;
    next_st.vs_sync  = {st.vs_sync[0], vsync_in}; // RQ9
    next_st.scl_sync = {st.scl_sync[0], scl_in};
    next_st.sda_sync = {st.sda_sync[0], sda_in};
    next_st.div      = !st.div;
    next_st.sda_f    = hs[7];
    next_st.sda_cnt  = hs[6:0];
    next_st.scl_f    = hc[7];
    next_st.scl_cnt  = hc[6:0];
    next_st.vs_prev  = st.vs_sync[1];

    // One-way mode: one bit per sync rising edge, eight data bits then a null bit.
    if (ddc1_on && vs_rise) begin
      next_st.d1_bits = (st.d1_bits == `DDC1_NULL_BIT) ? 4'h0 : st.d1_bits + 4'h1;
      if (st.d1_bits == 4'h0) begin
        if (st.ctrl[`DDC_CTL_SWFEED]) begin
          next_st.d1_sh  = {st.tx_byte[6:0], 1'b0}; // RQ15
          next_st.sda_oe = !st.tx_byte[7];
        end else begin
          fifo_pop       = 1'b1; // RQ7
          next_st.d1_sh  = {fifo_q[6:0], 1'b0};
          next_st.sda_oe = !fifo_q[7];
        end
      end else if (st.d1_bits == `DDC1_NULL_BIT) begin
        next_st.sda_oe = 1'b0;
        if (st.ctrl[`DDC_CTL_SWFEED]) begin
          next_st.ctrl[`DDC_CTL_D1IRQ] = 1'b1; // RQ15
        end
      end else begin
        next_st.d1_sh  = {st.d1_sh[6:0], 1'b0};
        next_st.sda_oe = !st.d1_sh[7];
      end
    end

    // A falling clock edge from the host while in one-way mode switches to serial mode until the core clears the enable.
    if (ddc1_on && scl_fall) begin
      next_st.ctrl[`DDC_CTL_MODE]  = 1'b1; // RQ17
      next_st.ctrl[`DDC_CTL_SWIRQ] = 1'b1;
      next_st.sda_oe               = 1'b0;
      next_st.d1_bits              = 4'h0;
    end

    // Serial slave. Only the data line is ever driven; the clock is input only.
    if (serial_on) begin // RQ8
      unique case (st.phase)
        DDC_IDLE: ;
        DDC_ADDR, DDC_RX: begin
          if (scl_rise) begin
            next_st.shreg = {st.shreg[6:0], st.sda_f}; // RQ14
            next_st.bits  = st.bits + 4'h1;
          end else if (scl_fall && st.bits == `DDC_BYTE_BITS) begin
            next_st.bits  = 4'h0;
            next_st.phase = DDC_ACK;
            if (st.phase == DDC_ADDR) begin
              if (addr_hit) begin
                next_st.rw                 = st.shreg[0];
                next_st.sda_oe             = 1'b1;
                next_st.ssta[`DDC_SSTA_SLV] = 1'b1;
                next_st.ssta[`DDC_SSTA_TX]  = st.shreg[0];
              end else begin
                next_st.phase = DDC_IDLE;
              end
            end else begin
              // A written byte sets the buffer offset for the next read.
              next_st.sdat     = st.shreg;
              next_st.ptr      = st.shreg & ptr_mask;
              next_st.fifo_cnt = 2'h0;
              next_st.sda_oe   = st.scon[`DDC_SCON_ACK];
              next_st.ssta[`DDC_SSTA_INTR] = 1'b1;
            end
          end
        end
        // A host ack of a read byte loads the next byte on the clock fall ending the slot, like an address ack.
        DDC_ACK, DDC_TX_ACK: begin
          if (scl_rise && st.phase == DDC_TX_ACK) begin
            next_st.nack = st.sda_f;
            next_st.ssta[`DDC_SSTA_NACK] = st.sda_f;
          end else if (scl_fall) begin
            next_st.sda_oe = 1'b0;
            next_st.phase  = st.rw ? DDC_TX : DDC_RX;
            if (st.phase == DDC_TX_ACK && st.nack) begin
              next_st.phase = DDC_IDLE;
            end else if (st.rw) begin
              if (st.ctrl[`DDC_CTL_SWFEED]) begin
                next_st.shreg  = st.sdat; // RQ15
                next_st.sda_oe = !st.sdat[7];
                next_st.ssta[`DDC_SSTA_INTR] = 1'b1;
              end else begin
                fifo_pop       = 1'b1; // RQ7
                next_st.shreg  = fifo_q;
                next_st.sda_oe = !fifo_q[7];
              end
            end
          end
        end
        DDC_TX: begin
          if (scl_fall) begin
            next_st.bits   = st.bits + 4'h1;
            next_st.shreg  = {st.shreg[6:0], 1'b0};
            next_st.sda_oe = (st.bits == `DDC_LAST_BIT) ? 1'b0 : !st.shreg[6];
            if (st.bits == `DDC_LAST_BIT) begin
              next_st.bits  = 4'h0;
              next_st.phase = DDC_TX_ACK;
            end
          end
        end
      endcase
      if (start_ev) begin
        next_st.phase  = DDC_ADDR;
        next_st.bits   = 4'h0;
        next_st.sda_oe = 1'b0;
      end else if (stop_ev) begin
        next_st.phase  = DDC_IDLE;
        next_st.sda_oe = 1'b0;
        if (st.ssta[`DDC_SSTA_SLV]) begin
          next_st.ssta[`DDC_SSTA_STOP] = 1'b1;
          next_st.ssta[`DDC_SSTA_INTR] = 1'b1;
        end
        next_st.ssta[`DDC_SSTA_SLV] = 1'b0;
        next_st.ssta[`DDC_SSTA_TX]  = 1'b0;
      end
    end else if (!ddc1_on) begin
      next_st.phase  = DDC_IDLE;
      next_st.sda_oe = 1'b0;
    end

    // Two-entry prefetch buffer: the drain side pops first, then the fill side pushes.
    // The fill only runs while an entry is free, so a slow host stalls the fetches.
    if (fifo_pop && st.fifo_cnt != 2'h0) begin
      next_st.fifo0    = st.fifo1;
      next_st.fifo_cnt = st.fifo_cnt - 2'h1;
    end
    if (st.fifo_cnt != 2'h2 && !st.ctrl[`DDC_CTL_SWFEED] && (ddc1_on || serial_on)) begin
      if (next_st.fifo_cnt == 2'h0) begin
        next_st.fifo0 = mem_q;
      end else begin
        next_st.fifo1 = mem_q;
      end
      next_st.fifo_cnt = next_st.fifo_cnt + 2'h1;
      next_st.ptr      = (st.ptr + 8'h01) & ptr_mask; // RQ11 RQ12
    end

    // Core writes. Flags set by hardware win over a clear written in the same cycle.
    if (sfr_wr) begin
      unique case (sfr_addr)
        `DDC_OFS_DDC_SETUP:   next_st.ddc_setup = sfr_wdata; // RQ5
        `DDC_OFS_BUS_SETUP:   next_st.bus_setup = sfr_wdata; // RQ5
        `DDC_OFS_TX_BYTE:     next_st.tx_byte   = sfr_wdata; // RQ10
        `DDC_OFS_SER_CONTROL: next_st.scon      = sfr_wdata; // RQ13
        `DDC_OFS_SER_DATA:    next_st.sdat      = sfr_wdata; // RQ13
        `DDC_OFS_OWN_ADDR:    next_st.sadr      = sfr_wdata; // RQ1
        `DDC_OFS_POINTER: begin
          next_st.ptr      = sfr_wdata & ptr_mask;
          next_st.fifo_cnt = 2'h0;
        end
        `DDC_OFS_CONTROL: begin
          next_st.ctrl[`DDC_CTL_SIZE]   = sfr_wdata[`DDC_CTL_SIZE];
          next_st.ctrl[`DDC_CTL_SWFEED] = sfr_wdata[`DDC_CTL_SWFEED];
          next_st.ctrl[`DDC_CTL_WILD]   = sfr_wdata[`DDC_CTL_WILD];
          next_st.ctrl[`DDC_CTL_D1EN]   = sfr_wdata[`DDC_CTL_D1EN];
          next_st.ctrl[`DDC_CTL_D1IRQ]  = next_st.ctrl[`DDC_CTL_D1IRQ]
                                        & (sfr_wdata[`DDC_CTL_D1IRQ] | !st.ctrl[`DDC_CTL_D1IRQ]);
          next_st.ctrl[`DDC_CTL_SWIRQ]  = next_st.ctrl[`DDC_CTL_SWIRQ]
                                        & (sfr_wdata[`DDC_CTL_SWIRQ] | !st.ctrl[`DDC_CTL_SWIRQ]);
          if (!sfr_wdata[`DDC_CTL_D1EN]) begin
            next_st.ctrl[`DDC_CTL_MODE] = 1'b0; // RQ17
          end
        end
        default: ;
      endcase
    end

    // A window access uses the present pointer, then steps it and drops stale prefetches.
    if (win_wr || win_rd) begin
      next_st.ptr      = (st.ptr + 8'h01) & ptr_mask; // RQ11 RQ12 RQ19
      next_st.fifo_cnt = 2'h0;
    end

    // Core reads answer on the next cycle; reading the status drops its request flag
    // unless hardware sets it from clear in that very cycle.
    if (sfr_rd) begin
      unique case (sfr_addr)
        `DDC_OFS_DDC_SETUP:   next_st.rdata = st.ddc_setup;
        `DDC_OFS_BUS_SETUP:   next_st.rdata = st.bus_setup;
        `DDC_OFS_BUF_WINDOW:  next_st.rdata = mem_q; // RQ19
        `DDC_OFS_TX_BYTE:     next_st.rdata = st.tx_byte;
        `DDC_OFS_POINTER:     next_st.rdata = st.ptr;
        `DDC_OFS_CONTROL:     next_st.rdata = {1'b0, st.ctrl[6:0]};
        `DDC_OFS_SER_CONTROL: next_st.rdata = st.scon;
        `DDC_OFS_SER_DATA:    next_st.rdata = st.sdat;
        `DDC_OFS_OWN_ADDR:    next_st.rdata = st.sadr;
        `DDC_OFS_SER_STATUS: begin
          next_st.rdata = st.ssta;
          if (st.ssta[`DDC_SSTA_INTR] == next_st.ssta[`DDC_SSTA_INTR]) begin
            next_st.ssta[`DDC_SSTA_INTR] = 1'b0;
            next_st.ssta[`DDC_SSTA_STOP] = 1'b0;
          end
        end
        default:              next_st.rdata = `DDC_RST_BYTE;
      endcase
    end
  end

  // State register. The pins idle high, so the synchronisers start high too.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st           <= '0;
      st.vs_sync   <= 2'h3;
      st.scl_sync  <= 2'h3;
      st.sda_sync  <= 2'h3;
      st.vs_prev   <= 1'b1;
      st.scl_f     <= 1'b1;
      st.sda_f     <= 1'b1;
      st.ddc_setup <= `DDC_RST_BYTE; // RQ5
      st.bus_setup <= `DDC_RST_BYTE; // RQ5
      st.tx_byte   <= `DDC_RST_BYTE; // RQ10
      st.ptr       <= `DDC_RST_BYTE;
      st.sadr      <= OWN_ADDR_RESET;
      st.phase     <= DDC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Display buffer, written only by the core through the window; it has no reset.
  always_ff @(posedge clock) begin
    if (win_wr) begin
      buffer_mem[st.ptr] <= sfr_wdata; // RQ6 RQ20
    end
  end

  // Outputs straight from the state register; the pad only ever pulls low.
  assign sfr_rdata           = st.rdata;
  assign sda_out             = 1'b0;
  assign sda_oe              = st.sda_oe;
  assign ddc1_byte_irq       = st.ctrl[`DDC_CTL_D1IRQ];
  assign protocol_switch_irq = st.ctrl[`DDC_CTL_SWIRQ];
  assign serial_irq          = st.ssta[`DDC_SSTA_INTR];

endmodule // ddc_slave

// *** sim/ddc_slave_sva.sv ***
/*
  Port checker of the display data channel slave.
  Assumes it is bound to the slave and sees only the slave's ports.
*/
`timescale 1ns/1ps

module ddc_slave_sva
  import ddc_pkg::*;
(
  // Clock and reset.
  input wire logic       clock,
  input wire logic       arst_n,
  // Core register port.
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Pins and request levels.
  input wire logic       vsync_in,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       ddc1_byte_irq,
  input wire logic       protocol_switch_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // A write, one quiet cycle, then a read of the same register.
  sequence wr_gap_rd(logic [7:0] a);
    sfr_wr && sfr_addr == a ##1 !sfr_wr ##1 sfr_rd && sfr_addr == a;
  endsequence

  // Writes that clear a request bit; any other cycle must keep it.
  logic clr_switch;
  logic clr_byte;
  assign clr_switch = sfr_wr && sfr_addr == 8'hd7 && !sfr_wdata[1];
  assign clr_byte   = sfr_wr && sfr_addr == 8'hd7 && !sfr_wdata[3];

  tx_byte_rw_a: assert property (wr_gap_rd(8'hd5) |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("transmit byte read back differs from the write");
  ddc_setup_rw_a: assert property (wr_gap_rd(8'hd1) |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("hold setup read back differs from the write");
  unmapped_zero_a: assert property (sfr_rd && sfr_addr == 8'hc0 |=> sfr_rdata == 8'h00)
    else $error("unmapped read returned nonzero data");
  rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  data_open_drain_a: assert property (sda_out == 1'b0)
    else $error("data output drives high");
  ack_on_low_a: assert property ($rose(sda_oe) && !vsync_in |-> !scl_in)
    else $error("data pulled low while serial clock high");
  switch_cause_a: assert property ($rose(protocol_switch_irq) |-> !scl_in)
    else $error("mode switch flag set without a clock fall");
  switch_sticky_a: assert property (protocol_switch_irq && !clr_switch |=> protocol_switch_irq)
    else $error("mode switch flag dropped by itself");
  byte_irq_sticky_a: assert property (ddc1_byte_irq && !clr_byte |=> ddc1_byte_irq)
    else $error("byte request dropped by itself");
  byte_irq_cause_a: assert property ($rose(ddc1_byte_irq) |-> vsync_in)
    else $error("byte request set outside a sync pulse");
endmodule // ddc_slave_sva

bind ddc_slave ddc_slave_sva chk (.clock(clock), .arst_n(arst_n), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .vsync_in(vsync_in), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .ddc1_byte_irq(ddc1_byte_irq), .protocol_switch_irq(protocol_switch_irq));

// *** sim/ddc_host_model.sv ***
/*
  Behavioural display host on the two-wire link: start, stop and byte transfers.
  Assumes its tasks are called just after a rising clock edge; the data line has a pull-up.
*/
`timescale 1ns/1ps

module ddc_host_model #(
  parameter int HALF = 60
) (
  // Clock.
  input  wire logic clock,
  // Pull-down request of the slave.
  input  wire logic sda_oe,
  // Wire levels seen by both parties.
  output logic      scl,
  output logic      sda
);
  logic sda_drv;

  // The pull-up wins unless some party pulls the line low.
  assign sda = sda_drv & ~sda_oe;

  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic half();
    repeat (HALF) @(posedge clock);
  endtask

  // Data falls while the clock is high; works as a repeated start too.
  task automatic start_c();
    sda_drv <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_drv <= 1'b0;
    half();
    scl <= 1'b0;
    half();
  endtask

  task automatic stop_c();
    sda_drv <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_drv <= 1'b1;
    half();
  endtask

  // Data changes half a period after the clock fall, so it never moves while high.
  task automatic bit_c(input logic b, output logic seen);
    sda_drv <= b;
    half();
    scl <= 1'b1;
    half();
    seen = sda;
    scl <= 1'b0;
    half();
  endtask

  // Eight bits most significant first, then the acknowledge slot.
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_c(d[i], q[i]);
    bit_c(ack_in, ack);
  endtask
endmodule // ddc_host_model

// *** sim/tb_ddc_slave.sv ***
/*
  Self-checking bench of the display data channel slave.
  Assumes the host model drives the link and the checker is bound to the slave.
*/
`timescale 1ns/1ps

module tb_ddc_slave;
  import ddc_pkg::*;
  logic       clock;
  logic       arst_n;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       vsync_in;
  logic       scl;
  logic       sda;
  logic       sda_oe;
  logic       ddc1_byte_irq;
  logic       protocol_switch_irq;
  logic       serial_irq;
  logic [7:0] q;
  logic       ack;
  int         error_cnt;
  int         compares;

  ddc_slave dut (.clock(clock), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .vsync_in(vsync_in),
    .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .ddc1_byte_irq(ddc1_byte_irq),
    .protocol_switch_irq(protocol_switch_irq), .serial_irq(serial_irq));
  ddc_host_model host (.clock(clock), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Register port: one strobe cycle per access; read data sampled mid-cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clock);
    sfr_rd <= 1'b0;
    @(negedge clock);
    chk($sformatf("register %h", a), sfr_rdata & m, e);
  endtask

  // One sync pulse; the bit shows on the data pull-down while sync is high.
  task automatic vbit(input logic e);
    @(posedge clock);
    vsync_in <= 1'b1;
    repeat (8) @(negedge clock);
    chk("sda_oe", {7'h00, sda_oe}, {7'h00, e});
    @(posedge clock);
    vsync_in <= 1'b0;
    repeat (8) @(posedge clock);
  endtask

  task automatic send1(input logic [7:0] b);
    for (int i = 0; i < 9; i++) vbit(i < 8 ? ~b[7 - i] : 1'b0);
  endtask

  task automatic t_reset();
    rchk(8'hd1, 8'hff, 8'h00);
    rchk(8'hd2, 8'hff, 8'h00);
    rchk(8'hd5, 8'hff, 8'h00);
    rchk(8'hd6, 8'hff, 8'h00);
    rchk(8'hd7, 8'hff, 8'h00);
    rchk(8'hdb, 8'hfe, 8'ha0);
  endtask

  task automatic t_regs();
    wr(8'hd1, 8'h8b);
    rchk(8'hd1, 8'hff, 8'h8b);
    wr(8'hd2, 8'hff);
    rchk(8'hd2, 8'hff, 8'hff);
    wr(8'hd5, 8'h5a);
    rchk(8'hd5, 8'hff, 8'h5a);
    rchk(8'hc0, 8'hff, 8'h00);
    wr(8'hd7, 8'hff);
    rchk(8'hd7, 8'hff, 8'h74);
    wr(8'hd7, 8'h00);
  endtask

  // Pointer wraps at the top of the selected buffer size.
  task automatic t_window();
    wr(8'hd7, 8'h40);
    wr(8'hd6, 8'hfe);
    wr(8'hd4, 8'h11);
    wr(8'hd4, 8'h22);
    rchk(8'hd6, 8'hff, 8'h00);
    wr(8'hd6, 8'hfe);
    rchk(8'hd4, 8'hff, 8'h11);
    rchk(8'hd4, 8'hff, 8'h22);
    wr(8'hd7, 8'h00);
    wr(8'hd6, 8'h7f);
    wr(8'hd4, 8'h5a);
    wr(8'hd6, 8'h7f);
    rchk(8'hd4, 8'hff, 8'h5a);
    rchk(8'hd6, 8'hff, 8'h00);
  endtask

  task automatic t_ddc1();
    wr(8'hd7, 8'h40);
    send1(8'hff);
    wr(8'hd6, 8'h00);
    wr(8'hd4, 8'hc3);
    wr(8'hd7, 8'h44);
    wr(8'hd6, 8'h00);
    repeat (10) @(posedge clock);
    send1(8'hc3);
    wr(8'hd7, 8'h64);
    wr(8'hd5, 8'h96);
    send1(8'h96);
    chk("ddc1_byte_irq", {7'h00, ddc1_byte_irq}, 8'h01);
  endtask

  task automatic t_switch();
    host.start_c();
    host.stop_c();
    chk("protocol_switch_irq", {7'h00, protocol_switch_irq}, 8'h01);
    rchk(8'hd7, 8'h03, 8'h03);
    wr(8'hd7, 8'h44);
    rchk(8'hd7, 8'hff, 8'h45);
  endtask

  task automatic t_ddc2();
    wr(8'hd6, 8'h00);
    wr(8'hd4, 8'hc3);
    wr(8'hd4, 8'h3c);
    wr(8'hd6, 8'h00);
    wr(8'hd8, 8'h44);
    host.start_c();
    host.xfer(8'ha4, 1'b1, q, ack);
    chk("ack", {7'h00, ack}, 8'h01);
    host.start_c();
    host.xfer(8'ha1, 1'b1, q, ack);
    chk("ack", {7'h00, ack}, 8'h00);
    host.xfer(8'hff, 1'b0, q, ack);
    chk("byte", q, 8'hc3);
    host.xfer(8'hff, 1'b1, q, ack);
    chk("byte", q, 8'h3c);
    host.stop_c();
    wr(8'hd7, 8'h54);
    host.start_c();
    host.xfer(8'ha7, 1'b1, q, ack);
    chk("ack", {7'h00, ack}, 8'h00);
    host.xfer(8'hff, 1'b1, q, ack);
    host.stop_c();
    wr(8'hd7, 8'h44);
    host.start_c();
    host.xfer(8'ha0, 1'b1, q, ack);
    host.xfer(8'h02, 1'b1, q, ack);
    chk("ack", {7'h00, ack}, 8'h00);
    host.stop_c();
    chk("serial_irq", {7'h00, serial_irq}, 8'h01);
    rchk(8'hda, 8'hff, 8'h02);
    rchk(8'hd9, 8'h60, 8'h60);
    rchk(8'hd9, 8'h60, 8'h00);
  endtask

  // Any hang ends the run as a failure.
  initial begin
    repeat (100000) @(posedge clock);
    error_cnt++;
    results();
  end

  initial begin
    error_cnt = 0;
    compares  = 0;
    arst_n    = 1'b0;
    sfr_addr  = 8'h00;
    sfr_wr    = 1'b0;
    sfr_rd    = 1'b0;
    sfr_wdata = 8'h00;
    vsync_in  = 1'b0;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    t_reset();
    t_regs();
    t_window();
    t_ddc1();
    t_switch();
    t_ddc2();
    results();
  end
endmodule // tb_ddc_slave
